// file: common/pps_pkg.sv
// Summary of operation
// - Standard mode accepts wider multiply, prescale, postscale
// - Standard postscale independent of prescale value
// - Standard mode adds analog operating-point value
// - Power-on: both synthesisers restricted, restricted values
// - System control bit 2 selects standard mode
// - System standard: first register prescale, second multiplier
// - System standard: added postscale and operating-point registers
// - Pixel style 100 external, 101 internal standard
// - Style 101 gives internal select extended meaning
// - Restricted internal pair style: eight banks of two; external pair four
// - Standard mode: four banks of four slots
// - Standard readbacks show multiplier and prescale used
// - Added readbacks show postscale and operating point
// - Restricted feedback divider is count plus 65
// - Restricted range bits set half-divide and postscaler
// - Restricted internal pair ignores select bit 3
package pps_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int         PPS_ADR_W         = 10;
  localparam logic [7:0] IDX_SYS_CTRL      = 8'h08;
  localparam logic [7:0] IDX_PIX_CTRL1     = 8'h10;
  localparam logic [7:0] IDX_PIX_CTRL2     = 8'h11;
  localparam logic [7:0] IDX_FIXED_REF     = 8'h14;
  localparam logic [7:0] IDX_SYS_PRESCALE  = 8'h15;
  localparam logic [7:0] IDX_SYS_MULT      = 8'h16;
  localparam logic [7:0] IDX_SYS_POST      = 8'h17;
  localparam logic [7:0] IDX_SYS_OP        = 8'h18;
  localparam logic [7:0] IDX_SLOT_BASE     = 8'h20;
  localparam logic [7:0] IDX_RB_POST       = 8'h8c;
  localparam logic [7:0] IDX_RB_OP         = 8'h8d;
  localparam logic [7:0] IDX_RB_MULT       = 8'h8e;
  localparam logic [7:0] IDX_RB_PRE        = 8'h8f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int STD_MODE_BIT = 2;
  localparam int DF_LSB       = 6;
  localparam int VCO_W        = 6;
  localparam int REF_W        = 5;

  // ---------------------------------------------------------------
  // Values after reset (restricted-mode meaning)
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_SYS_CTRL     = 8'h00;
  localparam logic [7:0] RST_PIX_CTRL1    = 8'h00;
  localparam logic [7:0] RST_PIX_CTRL2    = 8'h00;
  localparam logic [7:0] RST_FIXED_REF    = 8'h05;
  localparam logic [7:0] RST_SYS_PRESCALE = 8'h05;
  localparam logic [7:0] RST_SYS_MULT     = 8'h00;
  localparam logic [7:0] RST_SYS_POST     = 8'h01;
  localparam logic [7:0] RST_SYS_OP       = 8'h00;
  localparam logic [7:0] RST_SLOT0        = 8'h05;
  localparam logic [7:0] RST_SLOT1        = 8'h0e;
  localparam logic [7:0] RST_SLOT_OTHER   = 8'h00;

  // ---------------------------------------------------------------
  // Restricted-mode arithmetic
  // ---------------------------------------------------------------
  localparam logic [7:0] FB_OFFSET = 8'd65;
  localparam logic [7:0] POST_DIV4 = 8'd4;
  localparam logic [7:0] POST_DIV2 = 8'd2;
  localparam logic [7:0] POST_DIV1 = 8'd1;

  // ---------------------------------------------------------------
  // Pixel selection styles and bus phases
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    STYLE_EXT_DIRECT = 3'h0,
    STYLE_EXT_PAIR   = 3'h1,
    STYLE_INT_DIRECT = 3'h2,
    STYLE_INT_PAIR   = 3'h3,
    STYLE_STD_EXT    = 3'h4,
    STYLE_STD_INT    = 3'h5
  } pps_style_type;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'h0,
    BUS_FETCH  = 2'h1,
    BUS_ANSWER = 2'h3
  } pps_bus_type;

endpackage

// file: design/pps_slot_mem.sv
`timescale 1ns/1ns
// Sixteen pixel programming slots, one write port, two registered reads
module pps_slot_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  // Bus read port
  input  wire logic [AW-1:0] addr_a_i,
  output logic      [7:0]    rdata_a_o,
  // Scan read port
  input  wire logic [AW-1:0] addr_b_i,
  output logic      [7:0]    rdata_b_o
);
  import pps_pkg::*;

  logic [7:0] slot [DEPTH];  // Slot storage

  // ---------------------------------------------------------------
  // Storage with restricted-mode power-on contents
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot[i] <= RST_SLOT_OTHER;
      end
      slot[0] <= RST_SLOT0;
      slot[1] <= RST_SLOT1;
    end else if (we_i) begin
      slot[waddr_i] <= wdata_i;
    end
  end

  // Registered reads; reset keeps outputs defined
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_a_o <= 8'h00;
      rdata_b_o <= 8'h00;
    end else begin
      rdata_a_o <= slot[addr_a_i];
      rdata_b_o <= slot[addr_b_i];
    end
  end

endmodule

// file: design/pps_top.sv
`timescale 1ns/1ns
module pps_top (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [pps_pkg::PPS_ADR_W-1:0] adr_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [31:0]                   dat_i,
  output logic      [31:0]                   dat_o,
  output logic                               ack_o,
  // Frequency-select pins
  input  wire logic [1:0]              external_frequency_select_pins_i,
  // System clock synthesiser programming
  output logic                               sys_standard_mode_o,
  output logic      [7:0]                    sys_feedback_o,
  output logic      [7:0]                    sys_prescale_o,
  output logic                               sys_ref_half_o,
  output logic      [7:0]                    sys_postscale_o,
  output logic      [7:0]                    sys_operating_point_o,
  // Pixel synthesiser programming
  output logic                               pix_standard_mode_o,
  output logic      [7:0]                    pix_feedback_o,
  output logic      [7:0]                    pix_prescale_o,
  output logic                               pix_ref_half_o,
  output logic      [7:0]                    pix_postscale_o,
  output logic      [7:0]                    pix_operating_point_o
);
  import pps_pkg::*;

  // ---------------------------------------------------------------
  // Restricted-mode decode helpers, shared by both synthesisers
  // ---------------------------------------------------------------
  function automatic logic [7:0] fb_from_count(input logic [7:0] v);
    fb_from_count = {2'b00, v[VCO_W-1:0]} + FB_OFFSET;
  endfunction

  function automatic logic [7:0] post_from_range(input logic [1:0] df);
    case (df)
      2'b00:   post_from_range = POST_DIV4;
      2'b01:   post_from_range = POST_DIV2;
      default: post_from_range = POST_DIV1;
    endcase
  endfunction

  function automatic logic [7:0] ref_from_reg(input logic [7:0] v);
    ref_from_reg = {3'b000, v[REF_W-1:0]};
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  pps_bus_type   bus_state;        // Bus phase
  pps_bus_type   next_bus_state;   // Next bus phase
  logic [7:0]    system_clock_control;
  logic [7:0]    pixel_pll_control_one;
  logic [7:0]    pixel_pll_control_two;
  logic [7:0]    fixed_ref_divider;
  logic [7:0]    sys_pll_prescale_value;
  logic [7:0]    sys_pll_multiplier_value;
  logic [7:0]    sys_pll_postscale_value;
  logic [7:0]    sys_pll_operating_point;
  logic [1:0]    fs_meta;          // First synchroniser stage
  logic [1:0]    fs_sync;          // Pins usable by logic
  logic [1:0]    scan_cnt;         // Slot within bank being fetched
  logic [1:0]    scan_cnt_d;       // Matches scan read data
  logic [3:0]    scan_addr;        // Slot fetched this cycle
  logic [7:0]    scan_rdata;       // Slot value from memory
  logic [7:0]    act [4];          // Active bank values
  logic [7:0]    bus_rdata;        // Slot value for the bus
  logic [7:0]    idx;              // Register index of request
  logic          wr_now;           // Write lands this edge
  logic          slot_hit;         // Index lies in the slot range
  pps_style_type style;            // Decoded selection style
  logic [3:0]    internal_frequency_select;           // Internal frequency select
  logic [7:0]    rd_mux;           // Read value before register

  assign idx      = adr_i[9:2];
  assign slot_hit = (idx[7:4] == IDX_SLOT_BASE[7:4]);
  assign wr_now   = (bus_state == BUS_ANSWER) && we_i && sel_i[0];
  assign internal_frequency_select   = pixel_pll_control_two[3:0];

  // Reserved codes fall back to the power-on style
  always_comb begin
    case (pixel_pll_control_one[2:0])
      3'h1:    style = STYLE_EXT_PAIR;
      3'h2:    style = STYLE_INT_DIRECT;
      3'h3:    style = STYLE_INT_PAIR;
      3'h4:    style = STYLE_STD_EXT;
      3'h5:    style = STYLE_STD_INT;
      default: style = STYLE_EXT_DIRECT;
    endcase
  end

  // ---------------------------------------------------------------
  // Wishbone phases: request, fetch, answer with ack
  // ---------------------------------------------------------------
  always_comb begin
    case (bus_state)
      BUS_IDLE:  next_bus_state = (cyc_i && stb_i) ? BUS_FETCH : BUS_IDLE;
      BUS_FETCH: next_bus_state = BUS_ANSWER;
      default:   next_bus_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  assign ack_o = (bus_state == BUS_ANSWER);

  // Read mux; unmapped indices read as zero
  always_comb begin
    case (idx)
      IDX_SYS_CTRL:     rd_mux = system_clock_control;
      IDX_PIX_CTRL1:    rd_mux = pixel_pll_control_one;
      IDX_PIX_CTRL2:    rd_mux = pixel_pll_control_two;
      IDX_FIXED_REF:    rd_mux = fixed_ref_divider;
      IDX_SYS_PRESCALE: rd_mux = sys_pll_prescale_value;
      IDX_SYS_MULT:     rd_mux = sys_pll_multiplier_value;
      IDX_SYS_POST:     rd_mux = sys_pll_postscale_value;
      IDX_SYS_OP:       rd_mux = sys_pll_operating_point;
      IDX_RB_POST:      rd_mux = pix_postscale_o;
      IDX_RB_OP:        rd_mux = pix_operating_point_o;
      IDX_RB_MULT:      rd_mux = pix_feedback_o;
      IDX_RB_PRE:       rd_mux = pix_prescale_o;
      default:          rd_mux = slot_hit ? bus_rdata : 8'h00;
    endcase
  end

  // Read data registered during fetch, held until next fetch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_state == BUS_FETCH) begin
      dat_o <= {24'h00_0000, rd_mux};
    end
  end

  // ---------------------------------------------------------------
  // Control registers; writes land on the acknowledging edge
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_clock_control     <= RST_SYS_CTRL;
      pixel_pll_control_one    <= RST_PIX_CTRL1;
      pixel_pll_control_two    <= RST_PIX_CTRL2;
      fixed_ref_divider        <= RST_FIXED_REF;
      sys_pll_prescale_value   <= RST_SYS_PRESCALE;
      sys_pll_multiplier_value <= RST_SYS_MULT;
      sys_pll_postscale_value  <= RST_SYS_POST;
      sys_pll_operating_point  <= RST_SYS_OP;
    end else if (wr_now) begin
      case (idx)
        IDX_SYS_CTRL:     system_clock_control     <= dat_i[7:0];
        IDX_PIX_CTRL1:    pixel_pll_control_one    <= dat_i[7:0];
        IDX_PIX_CTRL2:    pixel_pll_control_two    <= dat_i[7:0];
        IDX_FIXED_REF:    fixed_ref_divider        <= dat_i[7:0];
        IDX_SYS_PRESCALE: sys_pll_prescale_value   <= dat_i[7:0];
        IDX_SYS_MULT:     sys_pll_multiplier_value <= dat_i[7:0];
        IDX_SYS_POST:     sys_pll_postscale_value  <= dat_i[7:0];
        IDX_SYS_OP:       sys_pll_operating_point  <= dat_i[7:0];
        default:          ;  // Readbacks and unmapped ignore writes
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin synchroniser and bank scanner
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_meta <= 2'b00;
      fs_sync <= 2'b00;
    end else begin
      fs_meta <= external_frequency_select_pins_i;
      fs_sync <= fs_meta;
    end
  end

  // Slot of the selected bank for the current scan step
  always_comb begin
    case (style)
      STYLE_EXT_PAIR:   scan_addr = {1'b0, fs_sync, scan_cnt[0]};
      STYLE_INT_DIRECT: scan_addr = internal_frequency_select;
      STYLE_INT_PAIR:   scan_addr = {internal_frequency_select[2:0], scan_cnt[0]};
      STYLE_STD_EXT:    scan_addr = {fs_sync, scan_cnt};
      STYLE_STD_INT:    scan_addr = {internal_frequency_select[1:0], scan_cnt};
      default:          scan_addr = {2'b00, fs_sync};
    endcase
  end

  // Refresh all four active values continuously; a bank change
  // settles within a few cycles, far below any lock time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_cnt   <= 2'b00;
      scan_cnt_d <= 2'b00;
      for (int i = 0; i < 4; i++) begin
        act[i] <= 8'h00;
      end
    end else begin
      scan_cnt         <= scan_cnt + 2'b01;
      scan_cnt_d       <= scan_cnt;
      act[scan_cnt_d]  <= scan_rdata;
    end
  end

  pps_slot_mem #(
    .DEPTH (16),
    .AW    (4)
  ) u_slots (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (wr_now && slot_hit),
    .waddr_i   (idx[3:0]),
    .wdata_i   (dat_i[7:0]),
    .addr_a_i  (idx[3:0]),
    .rdata_a_o (bus_rdata),
    .addr_b_i  (scan_addr),
    .rdata_b_o (scan_rdata)
  );

  // ---------------------------------------------------------------
  // System synthesiser decode
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_standard_mode_o   <= 1'b0;
      sys_feedback_o        <= 8'h00;
      sys_prescale_o        <= 8'h00;
      sys_ref_half_o        <= 1'b0;
      sys_postscale_o       <= 8'h00;
      sys_operating_point_o <= 8'h00;
    end else if (system_clock_control[STD_MODE_BIT]) begin
      sys_standard_mode_o   <= 1'b1;
      sys_prescale_o        <= sys_pll_prescale_value;
      sys_feedback_o        <= sys_pll_multiplier_value;
      sys_ref_half_o        <= 1'b0;
      sys_postscale_o       <= sys_pll_postscale_value;
      sys_operating_point_o <= sys_pll_operating_point;
    end else begin
      sys_standard_mode_o   <= 1'b0;
      sys_prescale_o        <= ref_from_reg(sys_pll_prescale_value);
      sys_feedback_o <= fb_from_count(sys_pll_multiplier_value);
      sys_ref_half_o <= (sys_pll_multiplier_value[7:6] != 2'b11);
      sys_postscale_o <= post_from_range(sys_pll_multiplier_value[7:6]);
      sys_operating_point_o <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Pixel synthesiser decode
  // ---------------------------------------------------------------
  logic [7:0] pix_ref_src;  // Restricted reference register in use

  // Pair styles take N from the bank; direct styles the fixed divider
  assign pix_ref_src = (style == STYLE_EXT_PAIR || style == STYLE_INT_PAIR)
                       ? act[1] : fixed_ref_divider;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_standard_mode_o   <= 1'b0;
      pix_feedback_o        <= 8'h00;
      pix_prescale_o        <= 8'h00;
      pix_ref_half_o        <= 1'b0;
      pix_postscale_o       <= 8'h00;
      pix_operating_point_o <= 8'h00;
    end else if (style == STYLE_STD_EXT || style == STYLE_STD_INT) begin
      pix_standard_mode_o   <= 1'b1;
      pix_feedback_o        <= act[0];
      pix_prescale_o        <= act[1];
      pix_ref_half_o        <= 1'b0;
      pix_postscale_o       <= act[2];
      pix_operating_point_o <= act[3];
    end else begin
      pix_standard_mode_o   <= 1'b0;
      pix_feedback_o        <= fb_from_count(act[0]);
      pix_prescale_o        <= ref_from_reg(pix_ref_src);
      pix_ref_half_o        <= (act[0][7:6] != 2'b11);
      pix_postscale_o       <= post_from_range(act[0][7:6]);
      pix_operating_point_o <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_sys_mode_follow: assert property (
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> sys_standard_mode_o == $past(system_clock_control[2]))
    else $error("system mode output does not follow control bit");

  chk_sys_std_values: assert property (
    @(posedge clk_i) disable iff (rst_i)
    system_clock_control[STD_MODE_BIT]
    |=> sys_prescale_o == $past(sys_pll_prescale_value)
        && sys_feedback_o == $past(sys_pll_multiplier_value))
    else $error("standard system prescale or multiplier wrong");

  chk_sys_std_extra: assert property (
    @(posedge clk_i) disable iff (rst_i)
    system_clock_control[STD_MODE_BIT]
    |=> sys_postscale_o == $past(sys_pll_postscale_value)
        && sys_operating_point_o == $past(sys_pll_operating_point))
    else $error("standard system postscale or operating point wrong");

  chk_sys_fb_offset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rst_i && !system_clock_control[STD_MODE_BIT]
    |=> sys_feedback_o == 8'(65 + $past(sys_pll_multiplier_value[5:0])))
    else $error("restricted feedback divider not count plus 65");

  chk_sys_range_div4: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rst_i && !system_clock_control[STD_MODE_BIT]
    && sys_pll_multiplier_value[7:6] == 2'b00
    |=> sys_postscale_o == 8'h04 && sys_ref_half_o)
    else $error("range 00 must halve reference and divide by four");

  chk_std_no_half: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (style == STYLE_STD_EXT || style == STYLE_STD_INT)
    |=> !pix_ref_half_o && pix_postscale_o == $past(act[2]))
    else $error("standard pixel postscale coupled to prescale");

  chk_power_on_mode: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> !sys_standard_mode_o && !pix_standard_mode_o
                     && pixel_pll_control_one == 8'h00)
    else $error("synthesisers not in restricted mode after reset");

  chk_int_pair_addr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    style == STYLE_INT_PAIR |-> scan_addr[3:1] == internal_frequency_select[2:0])
    else $error("restricted internal pair slot address wrong");

  chk_std_bank_addr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    style == STYLE_STD_EXT |-> scan_addr[3:2] == fs_sync
                               && scan_addr[1:0] == scan_cnt)
    else $error("standard external bank not chosen by pins");

  chk_readback_mult: assert property (
    @(posedge clk_i) disable iff (rst_i)
    bus_state == BUS_FETCH && idx == IDX_RB_MULT
    |=> dat_o[7:0] == $past(pix_feedback_o) && ack_o)
    else $error("multiplier readback wrong");

  chk_bus_ack_delay: assert property (
    @(posedge clk_i) disable iff (rst_i)
    bus_state == BUS_IDLE && cyc_i && stb_i |-> !ack_o ##1 !ack_o ##1 ack_o)
    else $error("ack not two cycles after request");

endmodule

// file: tb/pll_standard_programming_mode_test.sv
`timescale 1ns/1ns
module pll_standard_programming_mode_test;
  import pps_pkg::*;
  // Bench signals
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ok;
  logic [9:0]  adr = 0;
  logic [31:0] dat = 0, dat_o;
  logic [3:0]  sel = 4'h1;
  logic [1:0]  pins = 0;
  logic        ack_o, s_std, s_half, p_std, p_half;
  logic [7:0]  s_fb, s_pre, s_post, s_op, p_fb, p_pre, p_post, p_op;
  logic [7:0]  q, r, pre, v [4], slot [16];
  int          miscompares = 0, n_compared = 0, seed = 74705;

  always #25 clk_i = ~clk_i;

  pps_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o), .external_frequency_select_pins_i(pins),
    .sys_standard_mode_o(s_std), .sys_feedback_o(s_fb),
    .sys_prescale_o(s_pre), .sys_ref_half_o(s_half),
    .sys_postscale_o(s_post), .sys_operating_point_o(s_op),
    .pix_standard_mode_o(p_std), .pix_feedback_o(p_fb),
    .pix_prescale_o(p_pre), .pix_ref_half_o(p_half),
    .pix_postscale_o(p_post), .pix_operating_point_o(p_op));
  pps_pll_core core_u (.clk_i(clk_i), .standard_mode_i(s_std),
    .prescale_i(s_pre), .legal_o(ok));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic single cycle; holds until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; dat <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc <= 0; stb <= 0; we <= 0;
  endtask

  // Restricted postscale from the range bits
  function automatic logic [7:0] post_of(input logic [1:0] df);
    return (df == 2'b00) ? 8'd4 : (df == 2'b01) ? 8'd2 : 8'd1;
  endfunction

  // Standard bank k: outputs and all four readbacks
  task automatic pix_chk(input int k);
    repeat (12) @(posedge clk_i);
    chk("p_std", {7'h0, p_std}, 8'h01);
    chk("p_fb", p_fb, slot[4*k]);
    chk("p_pre", p_pre, slot[4*k+1]);
    chk("p_post", p_post, slot[4*k+2]);
    chk("p_op", p_op, slot[4*k+3]);
    wb(0, IDX_RB_MULT, 0); chk("rb_m", q, slot[4*k]);
    wb(0, IDX_RB_PRE, 0); chk("rb_n", q, slot[4*k+1]);
    wb(0, IDX_RB_POST, 0); chk("rb_p", q, slot[4*k+2]);
    wb(0, IDX_RB_OP, 0); chk("rb_c", q, slot[4*k+3]);
  endtask

  // Hang guard, well beyond the fewer than 900 cycles needed
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    repeat (12) @(posedge clk_i);
    // Power-on values give a running restricted setup
    chk("s_std", {7'h0, s_std}, 8'h00);
    chk("s_fb", s_fb, 8'd65);
    chk("p_fb", p_fb, 8'd70);
    chk("p_pre", p_pre, RST_FIXED_REF);
    wb(0, IDX_SYS_POST, 0); chk("r_post", q, RST_SYS_POST);
    wb(0, IDX_SLOT_BASE + 8'h01, 0); chk("r_f1", q, RST_SLOT1);
    $display("test reset finished");
    // Restricted system decode, corners then random
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'hff : (i == 1) ? 8'h40 : 8'($random(seed));
      pre = (i == 0) ? 8'd2 : (i == 1) ? 8'd31 :
            8'd2 + 8'($unsigned($random(seed)) % 30);
      wb(1, IDX_SYS_MULT, r);
      wb(1, IDX_SYS_PRESCALE, pre);
      repeat (4) @(posedge clk_i);
      chk("s_fb", s_fb, {2'b00, r[5:0]} + 8'd65);
      chk("s_post", s_post, post_of(r[7:6]));
      chk("s_half", {7'h0, s_half}, {7'h0, r[7:6] != 2'b11});
      chk("s_pre", s_pre, pre);
      chk("s_ok", {7'h0, ok}, 8'h01);
    end
    $display("test restricted system finished");
    // Standard system: four registers pass straight through
    wb(1, IDX_SYS_CTRL, 8'h04);
    for (int i = 0; i < 3; i++) begin
      foreach (v[j]) v[j] = (i == 0) ? 8'hff : 8'($random(seed));
      for (int j = 0; j < 4; j++) wb(1, IDX_SYS_PRESCALE + 8'(j), v[j]);
      repeat (4) @(posedge clk_i);
      chk("s_std", {7'h0, s_std}, 8'h01);
      chk("s_pre", s_pre, v[0]);
      chk("s_fb", s_fb, v[1]);
      chk("s_post", s_post, v[2]);
      chk("s_op", s_op, v[3]);
    end
    $display("test standard system finished");
    // Fill the slots, then both standard selection styles
    foreach (slot[k]) begin
      slot[k] = 8'($random(seed));
      wb(1, IDX_SLOT_BASE + 8'(k), slot[k]);
    end
    wb(1, IDX_PIX_CTRL1, 8'h04);
    for (int k = 0; k < 4; k++) begin
      pins <= 2'(k);
      pix_chk(k);
    end
    wb(1, IDX_PIX_CTRL1, 8'h05);
    for (int k = 0; k < 4; k++) begin
      pins <= 2'(3 - k);
      wb(1, IDX_PIX_CTRL2, 8'(k));
      pix_chk(k);
    end
    $display("test standard pixel finished");
    // Restricted internal pairs; select bit 3 set and ignored
    wb(1, IDX_PIX_CTRL1, 8'h03);
    for (int k = 0; k < 8; k++) begin
      wb(1, IDX_PIX_CTRL2, 8'h08 | 8'(k));
      repeat (12) @(posedge clk_i);
      chk("p_fb", p_fb, {2'b00, slot[2*k][5:0]} + 8'd65);
      chk("p_pre", p_pre, {3'b000, slot[2*k+1][4:0]});
    end
    // Readback refuses writes; unmapped reads as zero
    wb(1, IDX_RB_MULT, ~p_fb);
    wb(0, IDX_RB_MULT, 0);
    chk("rb_ro", q, {2'b00, slot[14][5:0]} + 8'd65);
    wb(0, 8'h7f, 0);
    chk("unmapped", q, 8'h00);
    // Write with byte lane 0 off must be ignored
    sel <= 4'h0;
    wb(1, IDX_PIX_CTRL2, 8'h00);
    sel <= 4'h1;
    wb(0, IDX_PIX_CTRL2, 0);
    chk("sel_off", q, 8'h0f);
    // Remaining restricted styles: pins pick pair or slot, internal select picks slot
    for (int k = 0; k < 4; k++) begin
      pins <= 2'(k);
      wb(1, IDX_PIX_CTRL1, 8'h01);
      repeat (12) @(posedge clk_i);
      chk("p_std", {7'h0, p_std}, 8'h00);
      chk("p_fb", p_fb, {2'b00, slot[2*k][5:0]} + 8'd65);
      chk("p_pre", p_pre, {3'b000, slot[2*k+1][4:0]});
      wb(1, IDX_PIX_CTRL1, 8'h00);
      repeat (12) @(posedge clk_i);
      r = slot[k];
      chk("p_fb", p_fb, {2'b00, r[5:0]} + 8'd65);
      chk("p_post", p_post, post_of(r[7:6]));
      chk("p_half", {7'h0, p_half}, {7'h0, r[7:6] != 2'b11});
      chk("p_pre", p_pre, RST_FIXED_REF);
      wb(1, IDX_PIX_CTRL1, 8'h02);
      wb(1, IDX_PIX_CTRL2, 8'h0c + 8'(k));
      repeat (12) @(posedge clk_i);
      chk("p_fb", p_fb, {2'b00, slot[12+k][5:0]} + 8'd65);
    end
    $display("test restricted pixel finished");
    print_verdict();
  end
endmodule

// file: tb/pps_pll_core.sv
`timescale 1ns/1ns
// -------------------------------------------------------------
// Analog synthesiser stand-in: flags programming it cannot run
// -------------------------------------------------------------
module pps_pll_core (
  // Clock
  input  wire logic       clk_i,
  // Programming from the block
  input  wire logic       standard_mode_i,
  input  wire logic [7:0] prescale_i,
  // Health
  output logic            legal_o
);
  // Reference count 0 or 1 leaves the loop undefined in restricted use
  always_ff @(posedge clk_i) begin
    legal_o <= standard_mode_i ||
               (prescale_i >= 8'd2 && prescale_i <= 8'd31);
  end
endmodule
